// ---- pkg/fp_unpack_pkg.sv ----
// shared formats, field layouts and exponent constants for the operand unpacker
package fp_unpack_pkg;

  // external operand formats
  typedef enum logic [2:0] {
    FMT_BYTE   = 3'b000,
    FMT_WORD   = 3'b001,
    FMT_LONG   = 3'b010,
    FMT_SINGLE = 3'b011,
    FMT_DOUBLE = 3'b100,
    FMT_EXT    = 3'b101,
    FMT_PACKED = 3'b110
  } fmt_t;

  // storage widths of the real formats
  localparam int SGL_BITS = 32;
  localparam int DBL_BITS = 64;
  localparam int EXT_BITS = 96;

  // exponent biases
  localparam logic [16:0] SGL_BIAS = 17'h0007f;
  localparam logic [16:0] DBL_BIAS = 17'h003ff;
  localparam logic [16:0] EXT_BIAS = 17'h03fff;

  // reserved exponent codes
  localparam logic [7:0] SGL_EXP_MAX = 8'hff;
  localparam logic [10:0] DBL_EXP_MAX = 11'h7ff;
  localparam logic [14:0] EXT_EXP_MAX = 15'h7fff;
  localparam logic [16:0] EXT_EXP_MAX_W = 17'h07fff;

  // field positions inside the 96-bit operand word (first byte fetched in [95:88])
  localparam int OPW_SIGN = 95;
  localparam int SGL_EXP_LSB = 87;
  localparam int SGL_FRAC_LSB = 64;
  localparam int DBL_EXP_LSB = 84;
  localparam int DBL_FRAC_LSB = 32;
  localparam int EXT_EXP_LSB = 80;

  // integer operands become mantissa {magnitude, 32 zeros} with this exponent
  localparam logic [16:0] INT_EXP = 17'h0401e;
  // pseudo-unlimited normalisation shift
  localparam logic [16:0] NO_LIMIT = 17'h00040;

  // one-hot class bit positions
  localparam int CL_NORM = 0;
  localparam int CL_DENORM = 1;
  localparam int CL_ZERO = 2;
  localparam int CL_INF = 3;
  localparam int CL_NAN = 4;

  typedef struct packed {
    logic op_valid;
    logic op_sign;
    logic [14:0] op_exp;
    logic [63:0] op_mant;
    logic [4:0] op_class;
    logic op_signaling;
    logic op_unsupported;
    logic res_valid;
    logic res_sign;
    logic [14:0] res_exp;
    logic [63:0] res_mant;
    logic res_underflow;
    logic res_overflow;
    logic res_zero;
  } state_t;

endpackage

// ---- verilog/fp_operand_format_unpacker.sv ----
// operand unpacker, classifier and result gradual-underflow stage
`timescale 1ns/1ps

module fp_operand_format_unpacker
  import fp_unpack_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // operand from the main processor
  input wire logic in_valid,
  input wire fp_unpack_pkg::fmt_t in_fmt,
  input wire logic [95:0] in_data,
  // unpacked operand
  output logic op_valid,
  output logic op_sign,
  output logic [14:0] op_exp,
  output logic [63:0] op_mant,
  output logic [4:0] op_class,
  output logic op_signaling,
  output logic op_unsupported,
  // raw intermediate result
  input wire logic res_in_valid,
  input wire logic res_in_sign,
  input wire logic signed [16:0] res_in_exp,
  input wire logic [63:0] res_in_mant,
  // stored result
  output logic res_valid,
  output logic res_sign,
  output logic [14:0] res_exp,
  output logic [63:0] res_mant,
  output logic res_underflow,
  output logic res_overflow,
  output logic res_zero
);
  import fp_unpack_pkg::*;

  state_t state;
  state_t next_state;

  // ----------------------------------------------------------------
  // normalisation helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] lead_zeros(input logic [63:0] m);
    logic [6:0] n;
    n = 7'h40;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        n = 7'(63 - i);
      end
    end
    return n;
  endfunction

  // left shift stops at the limit so the exponent never goes below zero
  function automatic logic [80:0] normalize(input logic [16:0] e, input logic [63:0] m,
                                            input logic [16:0] limit);
    logic [16:0] sh;
    sh = {10'h000, lead_zeros(m)};
    if (sh > limit) begin
      sh = limit;
    end
    if (sh > 17'h0003f) begin
      sh = 17'h0003f;
    end
    return {e - sh, m << sh[5:0]};
  endfunction

  // ----------------------------------------------------------------
  // operand path
  // ----------------------------------------------------------------
  logic [7:0] s_exp;
  logic [22:0] s_frac;
  logic [10:0] d_exp;
  logic [51:0] d_frac;
  logic [14:0] x_exp;
  logic [63:0] x_mant;
  logic signed [31:0] int_val;
  logic [31:0] int_mag;
  logic [80:0] norm;

  assign s_exp = in_data[OPW_SIGN-1:SGL_EXP_LSB];
  assign s_frac = in_data[SGL_EXP_LSB-1:SGL_FRAC_LSB];
  assign d_exp = in_data[OPW_SIGN-1:DBL_EXP_LSB];
  assign d_frac = in_data[DBL_EXP_LSB-1:DBL_FRAC_LSB];
  assign x_exp = in_data[OPW_SIGN-1:EXT_EXP_LSB];
  assign x_mant = in_data[63:0];

  always_comb begin
    case (in_fmt)
      FMT_BYTE: int_val = {{24{in_data[95]}}, in_data[95:88]};
      FMT_WORD: int_val = {{16{in_data[95]}}, in_data[95:80]};
      default: int_val = in_data[95:64];
    endcase
    int_mag = int_val[31] ? 32'(-int_val) : int_val;
  end

  always_comb begin
    logic [16:0] e;
    logic [63:0] m;
    logic [16:0] lim;
    e = 17'h00000;
    m = 64'h0;
    lim = NO_LIMIT;
    next_state = state;
    next_state.op_valid = in_valid;
    next_state.op_signaling = 1'b0;
    next_state.op_unsupported = 1'b0;
    next_state.op_class = 5'h00;
    next_state.op_sign = in_data[OPW_SIGN];
    case (in_fmt)
      FMT_BYTE, FMT_WORD, FMT_LONG: begin
        next_state.op_sign = int_val[31];
        e = INT_EXP;
        m = {int_mag, 32'h0};
        next_state.op_class[int_mag == 32'h0 ? CL_ZERO : CL_NORM] = 1'b1;
      end
      FMT_SINGLE: begin
        m = {s_exp != 8'h00, s_frac, 40'h0};
        e = (s_exp == SGL_EXP_MAX) ? EXT_EXP_MAX_W :
            (s_exp == 8'h00) ? 17'(17'h1 + EXT_BIAS - SGL_BIAS) :
            17'({9'h0, s_exp} + EXT_BIAS - SGL_BIAS);
        if (s_exp == SGL_EXP_MAX) begin
          next_state.op_class[s_frac == 23'h0 ? CL_INF : CL_NAN] = 1'b1;
          next_state.op_signaling = s_frac != 23'h0 && !s_frac[22];
        end else if (s_exp == 8'h00) begin
          next_state.op_class[s_frac == 23'h0 ? CL_ZERO : CL_DENORM] = 1'b1;
        end else begin
          next_state.op_class[CL_NORM] = 1'b1;
        end
      end
      FMT_DOUBLE: begin
        m = {d_exp != 11'h000, d_frac, 11'h0};
        e = (d_exp == DBL_EXP_MAX) ? EXT_EXP_MAX_W :
            (d_exp == 11'h000) ? 17'(17'h1 + EXT_BIAS - DBL_BIAS) :
            17'({6'h0, d_exp} + EXT_BIAS - DBL_BIAS);
        if (d_exp == DBL_EXP_MAX) begin
          next_state.op_class[d_frac == 52'h0 ? CL_INF : CL_NAN] = 1'b1;
          next_state.op_signaling = d_frac != 52'h0 && !d_frac[51];
        end else if (d_exp == 11'h000) begin
          next_state.op_class[d_frac == 52'h0 ? CL_ZERO : CL_DENORM] = 1'b1;
        end else begin
          next_state.op_class[CL_NORM] = 1'b1;
        end
      end
      FMT_EXT: begin
        e = {2'b00, x_exp};
        m = x_mant;
        lim = 17'h00000;
        if (x_exp == EXT_EXP_MAX) begin
          next_state.op_class[x_mant[62:0] == 63'h0 ? CL_INF : CL_NAN] = 1'b1;
          next_state.op_signaling = x_mant[62:0] != 63'h0 && !x_mant[62];
        end else if (x_mant == 64'h0) begin
          e = 17'h00000;
          next_state.op_class[CL_ZERO] = 1'b1;
        end else if (x_exp == 15'h0000) begin
          next_state.op_class[x_mant[63] ? CL_NORM : CL_DENORM] = 1'b1;
        end else begin
          // unnormal: shift up, giving up at exponent zero
          lim = e;
          next_state.op_class[(lead_zeros(x_mant) > 7'(e > 17'h40 ? 17'h40 : e)) ?
                              CL_DENORM : CL_NORM] = 1'b1;
        end
      end
      default: begin
        // decimal strings need a converter this block does not hold
        next_state.op_unsupported = 1'b1;
        next_state.op_class[CL_ZERO] = 1'b1;
      end
    endcase
    norm = normalize(e, m, lim);
    // a zero mantissa would otherwise drag the exponent down by the full shift
    if (next_state.op_class[CL_ZERO]) begin
      next_state.op_exp = 15'h0000;
    end else begin
      next_state.op_exp = norm[78:64];
    end
    next_state.op_mant = norm[63:0];

    // ----------------------------------------------------------------
    // result path
    // ----------------------------------------------------------------
    next_state.res_valid = res_in_valid;
    next_state.res_sign = res_in_sign;
    next_state.res_underflow = 1'b0;
    next_state.res_overflow = 1'b0;
    if (res_in_exp <= 17'sh00000) begin
      // gradual underflow, no rounding applied
      next_state.res_underflow = 1'b1;
      next_state.res_exp = 15'h0000;
      next_state.res_mant = (-res_in_exp > 17'sh0003f) ? 64'h0 :
                            res_in_mant >> 6'(-res_in_exp);
    end else if (res_in_exp >= $signed(EXT_EXP_MAX_W)) begin
      next_state.res_overflow = 1'b1;
      next_state.res_exp = EXT_EXP_MAX;
      next_state.res_mant = res_in_mant;
    end else begin
      norm = normalize(res_in_exp, res_in_mant, res_in_exp);
      next_state.res_exp = norm[78:64];
      next_state.res_mant = norm[63:0];
    end
    next_state.res_zero = next_state.res_mant == 64'h0;
    if (next_state.res_zero && !next_state.res_overflow) begin
      next_state.res_exp = 15'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign op_valid = state.op_valid;
  assign op_sign = state.op_sign;
  assign op_exp = state.op_exp;
  assign op_mant = state.op_mant;
  assign op_class = state.op_class;
  assign op_signaling = state.op_signaling;
  assign op_unsupported = state.op_unsupported;
  assign res_valid = state.res_valid;
  assign res_sign = state.res_sign;
  assign res_exp = state.res_exp;
  assign res_mant = state.res_mant;
  assign res_underflow = state.res_underflow;
  assign res_overflow = state.res_overflow;
  assign res_zero = state.res_zero;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence single_in(logic [7:0] ev);
    in_valid && in_fmt == FMT_SINGLE && s_exp == ev;
  endsequence

  chk_class_onehot: assert property (op_valid |-> $onehot(op_class))
    else $error("operand class not one-hot");
  chk_single_zero: assert property (single_in(8'h00) ##0 s_frac == 23'h0 |=>
      op_class[CL_ZERO] && op_exp == 15'h0 && op_sign == $past(in_data[95]))
    else $error("single zero misclassified");
  chk_single_denorm: assert property (single_in(8'h00) ##0 s_frac != 23'h0 |=>
      op_class[CL_DENORM] && op_mant[63])
    else $error("single denormal misclassified");
  chk_single_bias: assert property (single_in(8'h81) |=>
      op_class[CL_NORM] && op_exp == 15'h4001 && op_mant[63])
    else $error("single bias wrong");
  chk_double_nan: assert property (in_valid && in_fmt == FMT_DOUBLE && d_exp == DBL_EXP_MAX
      && d_frac != 52'h0 |=> op_class[CL_NAN] && op_signaling == !$past(d_frac[51]))
    else $error("double nan misclassified");
  chk_ext_inf: assert property (in_valid && in_fmt == FMT_EXT && x_exp == EXT_EXP_MAX
      && x_mant[62:0] == 63'h0 |=> op_class[CL_INF])
    else $error("extended infinity misclassified");
  chk_ext_zero_exp: assert property (in_valid && in_fmt == FMT_EXT && x_exp == 15'h0
      && x_mant[63] |=> op_class[CL_NORM])
    else $error("extended zero exponent with integer bit not normal");
  chk_norm_intbit: assert property (op_valid && op_class[CL_NORM] |-> op_mant[63])
    else $error("normal operand without integer bit");
  chk_no_unnorm: assert property (op_valid && op_exp != 15'h0 && op_exp != EXT_EXP_MAX
      |-> op_mant[63])
    else $error("unnormal operand leaked");
  chk_res_unnorm: assert property (res_valid && !res_overflow && res_exp != 15'h0
      |-> res_mant[63])
    else $error("unnormal result produced");
  chk_unfl_flag: assert property (res_in_valid && res_in_exp <= 17'sh0 |=>
      res_underflow && res_exp == 15'h0)
    else $error("underflow not handled");
  chk_ovfl_flag: assert property (res_in_valid && res_in_exp >= 17'sh07fff |=>
      res_overflow && !res_underflow)
    else $error("overflow not flagged");

endmodule // fp_operand_format_unpacker

// ---- sim/operand_source.sv ----
// main-processor model that places memory operands onto the operand word
`timescale 1ns/1ps
module operand_source
  import fp_unpack_pkg::*;
(
  // clock
  input wire logic core_clk,
  // operand word toward the unpacker
  output logic in_valid,
  output fp_unpack_pkg::fmt_t in_fmt,
  output logic [95:0] in_data
);
  logic flip = 1'b0;
  logic [95:0] word = 96'h0;
  logic [95:0] mask = 96'h0;
  // bytes not fetched change every cycle so that a leak into the result shows
  always @(negedge core_clk) flip <= ~flip;
  assign in_data = (word & mask) | ({3{flip ? 32'haaaaaaaa : 32'h55555555}} & ~mask);
  initial begin
    in_valid = 1'b0;
    in_fmt = FMT_BYTE;
  end
  // v is right-justified; lowest address (most significant byte) goes on top
  task automatic send(input fmt_t f, input logic [95:0] v);
    in_valid = 1'b1;
    in_fmt = f;
    case (f)
      FMT_BYTE: word = {v[7:0], 88'h0};
      FMT_WORD: word = {v[15:0], 80'h0};
      FMT_LONG, FMT_SINGLE: word = {v[31:0], 64'h0};
      FMT_DOUBLE: word = {v[63:0], 32'h0};
      default: word = v;
    endcase
    case (f)
      FMT_BYTE: mask = {8'hff, 88'h0};
      FMT_WORD: mask = {16'hffff, 80'h0};
      FMT_LONG, FMT_SINGLE: mask = {32'hffffffff, 64'h0};
      FMT_DOUBLE: mask = {64'hffffffffffffffff, 32'h0};
      FMT_EXT: mask = {16'hffff, 16'h0, 64'hffffffffffffffff};
      default: mask = '1;
    endcase
  endtask
  task automatic idle();
    in_valid = 1'b0;
    mask = 96'h0;
  endtask
endmodule // operand_source

// ---- sim/tb.sv ----
// self-checking bench for the operand unpacker and result stage
`timescale 1ns/1ps
module tb;
  import fp_unpack_pkg::*;
  localparam logic [63:0] top = 64'h8000000000000000;
  localparam logic [63:0] tq = 64'hc000000000000000;
  typedef struct packed {
    fmt_t f;
    logic [95:0] v;
    logic s;
    logic [14:0] e;
    logic [63:0] m;
    logic [4:0] c;
    logic sg;
  } row_t;
  localparam int n_rows = 24;
  row_t rows [n_rows] = '{
    '{FMT_SINGLE, 96'h3f800000, 1'b0, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_SINGLE, 96'hbf800000, 1'b1, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_SINGLE, 96'h00000000, 1'b0, 15'h0000, 64'h0, 5'h04, 1'b0},
    '{FMT_SINGLE, 96'h80000000, 1'b1, 15'h0000, 64'h0, 5'h04, 1'b0},
    '{FMT_SINGLE, 96'h7f800000, 1'b0, 15'h7fff, top, 5'h08, 1'b0},
    '{FMT_SINGLE, 96'h7fc00000, 1'b0, 15'h7fff, tq, 5'h10, 1'b0},
    '{FMT_SINGLE, 96'h7f800001, 1'b0, 15'h7fff, 64'h8000010000000000, 5'h10, 1'b1},
    '{FMT_SINGLE, 96'h00400000, 1'b0, 15'h3f80, top, 5'h02, 1'b0},
    '{FMT_DOUBLE, 96'h3ff0000000000000, 1'b0, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_DOUBLE, 96'h0000000000000001, 1'b0, 15'h3bcd, top, 5'h02, 1'b0},
    '{FMT_DOUBLE, 96'hfff0000000000000, 1'b1, 15'h7fff, top, 5'h08, 1'b0},
    '{FMT_DOUBLE, 96'h7ff8000000000000, 1'b0, 15'h7fff, tq, 5'h10, 1'b0},
    '{FMT_EXT, 96'h3fff00008000000000000000, 1'b0, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_EXT, 96'h000000008000000000000000, 1'b0, 15'h0000, top, 5'h01, 1'b0},
    '{FMT_EXT, 96'h000400002000000000000000, 1'b0, 15'h0002, top, 5'h01, 1'b0},
    '{FMT_EXT, 96'h000300002000000000000000, 1'b0, 15'h0001, top, 5'h01, 1'b0},
    '{FMT_EXT, 96'h800500000000000000000000, 1'b1, 15'h0000, 64'h0, 5'h04, 1'b0},
    '{FMT_EXT, 96'h7fff00000000000000000000, 1'b0, 15'h7fff, 64'h0, 5'h08, 1'b0},
    '{FMT_EXT, 96'h7fff00000000000000000001, 1'b0, 15'h7fff, 64'h1, 5'h10, 1'b1},
    '{FMT_BYTE, 96'h01, 1'b0, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_BYTE, 96'hff, 1'b1, 15'h3fff, top, 5'h01, 1'b0},
    '{FMT_WORD, 96'h8000, 1'b1, 15'h400e, top, 5'h01, 1'b0},
    '{FMT_LONG, 96'h00000000, 1'b0, 15'h0000, 64'h0, 5'h04, 1'b0},
    '{FMT_LONG, 96'h80000000, 1'b1, 15'h401e, top, 5'h01, 1'b0}};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic in_valid, op_valid, op_sign, op_signaling, op_unsupported;
  fmt_t in_fmt;
  logic [95:0] in_data;
  logic [14:0] op_exp, res_exp;
  logic [63:0] op_mant, res_mant, res_in_mant;
  logic [4:0] op_class;
  logic res_in_valid, res_in_sign, res_valid, res_sign, res_underflow, res_overflow, res_zero;
  logic signed [16:0] res_in_exp;
  int n_fail = 0;
  int samples_checked = 0;
  fp_operand_format_unpacker i_dut (.core_clk(core_clk), .reset(reset), .in_valid(in_valid),
    .in_fmt(in_fmt), .in_data(in_data), .op_valid(op_valid), .op_sign(op_sign),
    .op_exp(op_exp), .op_mant(op_mant), .op_class(op_class), .op_signaling(op_signaling),
    .op_unsupported(op_unsupported), .res_in_valid(res_in_valid), .res_in_sign(res_in_sign),
    .res_in_exp(res_in_exp), .res_in_mant(res_in_mant), .res_valid(res_valid),
    .res_sign(res_sign), .res_exp(res_exp), .res_mant(res_mant),
    .res_underflow(res_underflow), .res_overflow(res_overflow), .res_zero(res_zero));
  operand_source i_src (.core_clk(core_clk), .in_valid(in_valid), .in_fmt(in_fmt),
    .in_data(in_data));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic cmp(input string what, input logic [63:0] want, input logic [63:0] got);
    samples_checked++;
    if (want !== got) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // result path is held valid back to back across calls
  task automatic chk_res(input logic s, input logic signed [16:0] e, input logic [63:0] m,
      input logic [14:0] xe, input logic [63:0] xm, input logic [2:0] xf);
    res_in_valid = 1'b1;
    res_in_sign = s;
    res_in_exp = e;
    res_in_mant = m;
    @(negedge core_clk);
    cmp("res_valid", 64'h1, res_valid);
    cmp("res_sign", s, res_sign);
    cmp("res_exp", xe, res_exp);
    cmp("res_mant", xm, res_mant);
    cmp("res_flags uf/of/zero", xf, {res_underflow, res_overflow, res_zero});
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    res_in_valid = 1'b0;
    res_in_sign = 1'b0;
    res_in_exp = 17'sd0;
    res_in_mant = 64'h0;
    repeat (2) @(negedge core_clk);
    cmp("valids in reset", 64'h0, {op_valid, res_valid, op_class});
    reset = 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < n_rows; i++) begin
      i_src.send(rows[i].f, rows[i].v);
      @(negedge core_clk);
      cmp("op_valid", 64'h1, op_valid);
      cmp("op_class", rows[i].c, op_class);
      cmp("op_sign", rows[i].s, op_sign);
      cmp("op_exp", rows[i].e, op_exp);
      cmp("op_mant", rows[i].m, op_mant);
      cmp("op_signaling", rows[i].sg, op_signaling);
      cmp("op_unsupported", 64'h0, op_unsupported);
    end
    i_src.send(FMT_PACKED, 96'h3fff0000123456789abcdef0);
    @(negedge core_clk);
    cmp("packed flag", 64'h1, op_unsupported);
    cmp("packed class", 64'h4, op_class);
    i_src.idle();
    @(negedge core_clk);
    cmp("op_valid pulse", 64'h0, op_valid);
    // reset in mid-run wins over a presented operand
    i_src.send(FMT_SINGLE, 96'h3f800000);
    reset = 1'b1;
    @(negedge core_clk);
    cmp("op_valid under reset", 64'h0, {op_valid, op_class});
    i_src.idle();
    reset = 1'b0;
    @(negedge core_clk);
    chk_res(1'b0, -17'sd2, top, 15'h0000, 64'h2000000000000000, 3'b100);
    chk_res(1'b1, 17'sd0, top, 15'h0000, top, 3'b100);
    chk_res(1'b0, -17'sd64, top, 15'h0000, 64'h0, 3'b101);
    chk_res(1'b0, 17'sd32767, top, 15'h7fff, top, 3'b010);
    chk_res(1'b1, 17'sd1, 64'h4000000000000000, 15'h0000, top, 3'b000);
    chk_res(1'b0, 17'sd16384, 64'h2000000000000000, 15'h3ffe, top, 3'b000);
    chk_res(1'b1, 17'sd16383, 64'h0, 15'h0000, 64'h0, 3'b001);
    res_in_valid = 1'b0;
    @(negedge core_clk);
    cmp("res_valid pulse", 64'h0, res_valid);
    test_done();
  end
endmodule // tb
